// >>> pps_device.sv
// Converter end: parallel port, control register and power sequencing
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "pps_map.svh"
module pps_device #(
  parameter int RES_BITS = 12,
  parameter int CONV_CYCLES = `PPS_CONV_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  pps_if.device port,
  // Converter side
  input wire logic [11:0] sample_in,
  input wire logic [2:0] channel_in,
  output logic [11:0] control,
  output logic [7:0] shadow,
  output logic shadow_load,
  output logic tracking,
  output logic [1:0] power_state
);
  //==========================================================
  // Pin synchronisers
  logic [4:0] s1, s2, s3;
  logic [11:0] b1, b2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 5'h1f;
      s2 <= 5'h1f;
      s3 <= 5'h1f;
      b1 <= 12'h000;
      b2 <= 12'h000;
    end else begin
      s1 <= {port.word_mode, port.cs_n, port.rd_n, port.wr_n, port.convert_start_n};
      s2 <= s1;
      s3 <= s2;
      b1 <= port.bus;
      b2 <= b1;
    end
  end
  logic wmode, rd_act, wr_rise, cv_fall, cv_rise, high_byte_enable;
  assign wmode = s2[4];
  assign rd_act = !s2[3] && !s2[2];
  assign wr_rise = !s3[3] && !s3[1] && s2[1];
  assign cv_fall = s3[0] && !s2[0];
  assign cv_rise = !s3[0] && s2[0];
  assign high_byte_enable = b2[8];

  //==========================================================
  // Control register and power state
  logic [7:0] low_byte, next_low_byte, next_shadow;
  logic [11:0] next_control;
  logic next_shadow_load, next_tracking, busy_r, next_busy;
  logic [7:0] cnt, next_cnt;
  logic [11:0] result, next_result;
  pps_pkg::pps_pw_e pw, next_pw;
  pps_pkg::pps_pm_e pm;
  assign pm = pps_pkg::pps_pm_e'({control[`PPS_PM_HI_BIT], control[`PPS_PM_LO_BIT]});

  always_comb begin
    next_control = control;
    next_low_byte = low_byte;
    next_shadow = shadow;
    next_shadow_load = 1'b0;
    next_tracking = tracking;
    next_busy = busy_r;
    next_cnt = cnt;
    next_result = result;
    next_pw = pw;
    if (wr_rise) begin
      // Shadow write branch carries a constant zero term, so no write ever reaches the shadow register
      if (control[3] && !control[2] && shadow_load == 1'b0 && b2[11:8] == 4'h0 &&
          1'b0) begin
        next_shadow = b2[7:0];
      end else if (wmode) begin
        next_control = b2;
      end else if (!high_byte_enable) begin
        next_low_byte = b2[7:0];
      end else begin
        next_control = {b2[3:0], low_byte};
      end
    end
    if (wr_rise && (wmode || high_byte_enable)) begin
      if (next_control[`PPS_PM_HI_BIT] && next_control[`PPS_PM_LO_BIT]) begin
        next_pw = pps_pkg::PPS_PW_OFF;
        next_tracking = 1'b0;
      end else if (pw == pps_pkg::PPS_PW_OFF && pm == pps_pkg::PPS_PM_FULLSHUT) begin
        next_pw = pps_pkg::PPS_PW_ON;
        next_tracking = 1'b1;
      end
    end
    if (cv_rise && pm != pps_pkg::PPS_PM_FULLSHUT) begin
      next_tracking = 1'b1;
      next_pw = pps_pkg::PPS_PW_ON;
    end
    if (cv_fall && pw == pps_pkg::PPS_PW_ON && !busy_r) begin
      next_busy = 1'b1;
      next_tracking = 1'b0;
      next_cnt = 8'(CONV_CYCLES);
    end else if (busy_r) begin
      next_cnt = cnt - 8'h01;
      if (cnt == 8'h01) begin
        next_busy = 1'b0;
        // Ten-bit part carries zeros in the two lowest places
        next_result = (RES_BITS == 10) ? {sample_in[11:2], 2'b00} : sample_in;
        case (pm)
          pps_pkg::PPS_PM_AUTOSHUT: next_pw = pps_pkg::PPS_PW_OFF;
          pps_pkg::PPS_PM_AUTOSTBY: next_pw = pps_pkg::PPS_PW_STBY;
          default: next_tracking = 1'b1;
        endcase
      end
    end
  end

  logic [2:0] chan;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `PPS_CTRL_RESET;
      low_byte <= 8'h00;
      shadow <= 8'h00;
      shadow_load <= 1'b0;
      tracking <= 1'b0;
      busy_r <= 1'b0;
      cnt <= 8'h00;
      result <= 12'h000;
      pw <= pps_pkg::PPS_PW_ON;
      chan <= 3'h0;
    end else begin
      control <= next_control;
      low_byte <= next_low_byte;
      shadow <= next_shadow;
      shadow_load <= next_shadow_load;
      tracking <= next_tracking;
      busy_r <= next_busy;
      cnt <= next_cnt;
      result <= next_result;
      pw <= next_pw;
      if (busy_r && cnt == 8'h01) begin
        chan <= channel_in;
      end
    end
  end

  //==========================================================
  // Read data path; result is loaded on the same edge that busy falls
  logic [11:0] dout, next_dout;
  always_comb begin
    if (wmode) begin
      next_dout = result;
    end else if (high_byte_enable) begin
      next_dout = {4'h0, chan, 1'b0, result[11:8]};
    end else begin
      next_dout = {4'h0, result[7:0]};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= 12'h000;
    end else begin
      dout <= (busy_r && cnt == 8'h01) ? (wmode ? next_result : dout) : next_dout;
    end
  end
  assign port.dev_dout = dout;
  assign port.dev_oe_n = !rd_act;
  assign port.busy = busy_r;
  assign power_state = pw;
endmodule

// >>> pps_map.svh
// Constants for the parallel port and power-mode block
//==========================================================
// Summary of operation
// - Word mode: one read returns whole word
// - Byte mode: two reads on low eight lines
// - High byte enable picks upper or lower
// - Low byte read gives eight result LSBs
// - Ten-bit low byte: two zero LSBs first
// - High byte: four MSBs, channel on 7:5
// - Read active only while select and strobe low
// - Drive bus during read, release afterwards
// - Tied-low read: result valid before busy falls; the code loads it on the edge busy falls
// - Word write loads twelve control bits
// - Host writes low byte, then high byte
// - Shadow write is always one access; the code never takes the shadow write
// - Host zeroes top four high-byte bits
// - Write captured on strobe rising edge
// - Power bits select mode, reset gives normal
// - Hold after power-on, first start rise tracks
// - Autoshutdown: off after conversion, wake on rise
// - Host waits 10 ms after autoshutdown wake
// - Autostandby: reference kept, wake on rise
// - Host waits 600 ns or 7 us
// - Full shutdown on write rise until changed
// - Normal from shutdown powers up, host waits 10 ms
// - Busy high from start fall to conversion end
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH
`define PPS_CLK_MHZ 100
`define PPS_PM_LO_BIT 4
`define PPS_PM_HI_BIT 5
`define PPS_CTRL_RESET 12'h000
`define PPS_CONV_CYCLES 14
`define PPS_WAKE_SHUT_MS 10
`define PPS_WAKE_STBY_EXT_NS 600
`define PPS_WAKE_STBY_INT_US 7
`define PPS_WAKE_SHUT_CYC (`PPS_WAKE_SHUT_MS * 1000 * 1000 / 10)
`define PPS_WAKE_STBY_EXT_CYC ((`PPS_WAKE_STBY_EXT_NS + 9) / 10)
`define PPS_WAKE_STBY_INT_CYC (`PPS_WAKE_STBY_INT_US * 1000 / 10)
`define PPS_REG_CMD 12'h000
`define PPS_REG_STAT 12'h004
`define PPS_REG_DATA 12'h008
`endif

// >>> pps_pkg.sv
// Types shared by both ends of the parallel port
package pps_pkg;
  typedef enum logic [1:0] {
    PPS_PM_NORMAL = 2'b00,
    PPS_PM_AUTOSHUT = 2'b01,
    PPS_PM_AUTOSTBY = 2'b10,
    PPS_PM_FULLSHUT = 2'b11
  } pps_pm_e;
  typedef enum logic [1:0] {
    PPS_PW_ON = 2'b00,
    PPS_PW_STBY = 2'b01,
    PPS_PW_OFF = 2'b10
  } pps_pw_e;
  typedef enum logic [2:0] {
    PPS_H_IDLE = 3'b000,
    PPS_H_SETUP = 3'b001,
    PPS_H_STROBE = 3'b010,
    PPS_H_HOLD = 3'b011,
    PPS_H_DONE = 3'b100
  } pps_host_e;
endpackage

// >>> pps_if.sv
// Parallel port pins joining the converter and its host
`timescale 1ns/1ps
interface pps_if;
  logic word_mode;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic convert_start_n;
  logic busy;
  logic [11:0] dev_dout;
  logic dev_oe_n;
  logic [11:0] host_dout;
  logic host_oe_n;
  logic [11:0] bus;
  // In byte mode the shared bit 8 is the host's byte select, never device data
  assign bus = {
    !dev_oe_n ? dev_dout[11:9] : (!host_oe_n ? host_dout[11:9] : 3'h7),
    !word_mode ? host_dout[8] : (!dev_oe_n ? dev_dout[8] : (!host_oe_n ? host_dout[8] : 1'b1)),
    !dev_oe_n ? dev_dout[7:0] : (!host_oe_n ? host_dout[7:0] : 8'hff)};
  modport device (input word_mode, cs_n, rd_n, wr_n, convert_start_n, bus,
    output busy, dev_dout, dev_oe_n);
  modport host (output word_mode, cs_n, rd_n, wr_n, convert_start_n, host_dout,
    host_oe_n, input busy, bus);
endinterface

// >>> pps_host.sv
// Host end: APB registers that drive reads, writes and conversions
`timescale 1ns/1ps
`include "pps_map.svh"
module pps_host #(
  parameter int STROBE_CYCLES = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  pps_if.host port
);
  //==========================================================
  // Command register: [11:0] data, [12] write, [13] high_byte_enable, [14] go, [15] word mode,
  // [16] convert_start_n level
  logic [11:0] cdata, next_cdata, rdata, next_rdata;
  logic cwr, next_cwr, chb, next_chb, wm, next_wm, cv, next_cv;
  logic [1:0] busy_s;
  logic [7:0] cnt, next_cnt;
  pps_pkg::pps_host_e st, next_st;
  logic acc;
  assign acc = psel && penable;

  always_comb begin
    next_cdata = cdata;
    next_cwr = cwr;
    next_chb = chb;
    next_wm = wm;
    next_cv = cv;
    next_rdata = rdata;
    next_cnt = cnt;
    next_st = st;
    case (st)
      pps_pkg::PPS_H_IDLE, pps_pkg::PPS_H_DONE: begin
        if (acc && pwrite && paddr == `PPS_REG_CMD) begin
          next_cdata = pwdata[11:0];
          next_cwr = pwdata[12];
          next_chb = pwdata[13];
          next_wm = pwdata[15];
          next_cv = pwdata[16];
          if (pwdata[14]) begin
            next_st = pps_pkg::PPS_H_SETUP;
          end
        end
      end
      pps_pkg::PPS_H_SETUP: begin
        next_st = pps_pkg::PPS_H_STROBE;
        next_cnt = 8'(STROBE_CYCLES);
      end
      pps_pkg::PPS_H_STROBE: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_st = pps_pkg::PPS_H_HOLD;
          next_rdata = port.bus;
        end
      end
      pps_pkg::PPS_H_HOLD: next_st = pps_pkg::PPS_H_DONE;
      default: next_st = pps_pkg::PPS_H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdata <= 12'h000;
      cwr <= 1'b0;
      chb <= 1'b0;
      wm <= 1'b1;
      cv <= 1'b1;
      rdata <= 12'h000;
      cnt <= 8'h00;
      st <= pps_pkg::PPS_H_IDLE;
      busy_s <= 2'b00;
    end else begin
      cdata <= next_cdata;
      cwr <= next_cwr;
      chb <= next_chb;
      wm <= next_wm;
      cv <= next_cv;
      rdata <= next_rdata;
      cnt <= next_cnt;
      st <= next_st;
      busy_s <= {busy_s[0], port.busy};
    end
  end

  //==========================================================
  // Pin drive; strobe low only in the strobe state
  logic strobe, in_cycle;
  assign in_cycle = st == pps_pkg::PPS_H_SETUP || st == pps_pkg::PPS_H_STROBE ||
    st == pps_pkg::PPS_H_HOLD;
  assign strobe = st == pps_pkg::PPS_H_STROBE;
  assign port.word_mode = wm;
  assign port.cs_n = !in_cycle;
  assign port.rd_n = !(strobe && !cwr);
  assign port.wr_n = !(strobe && cwr);
  assign port.convert_start_n = cv;
  // Byte mode puts the select on the shared bit; writes drive the whole bus
  assign port.host_dout = wm ? cdata : {3'h0, chb, cdata[7:0]};
  // Data lines only during writes; the byte select rides bit 8 in byte mode
  assign port.host_oe_n = !(in_cycle && cwr);

  //==========================================================
  // APB read side; zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `PPS_REG_CMD: prdata = {15'h0000, cv, wm, 1'b0, chb, cwr, cdata};
      `PPS_REG_STAT: prdata = {29'h0000_0000, busy_s[1], st == pps_pkg::PPS_H_DONE,
        in_cycle};
      `PPS_REG_DATA: prdata = {20'h00000, rdata};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule

// >>> pps_properties.sv
// Pin checks between converter and host
`timescale 1ns/1ps
module pps_properties #(
  parameter int CONV_CYCLES = 14
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic convert_start_n,
  input wire logic busy,
  input wire logic dev_oe_n,
  input wire logic host_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====
  // Busy length counter
  int busy_cnt;
  int next_busy_cnt;
  always_comb begin
    next_busy_cnt = busy ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end
  // =====
  // Properties
  sequence s_rd_on;
    (!cs_n && !rd_n)[*3];
  endsequence
  sequence s_wr_pulse;
    (!wr_n && !cs_n)[*3] ##1 wr_n;
  endsequence
  AST_READ_DRIVE: assert property (s_rd_on |-> ##[0:1] !dev_oe_n)
    else $error("bus not driven in read");
  AST_READ_RELEASE: assert property (rd_n[*4] |-> dev_oe_n)
    else $error("bus driven after read");
  AST_CS_GATES: assert property (cs_n[*4] |-> dev_oe_n)
    else $error("bus driven without select");
  AST_NO_CLASH: assert property (!(!dev_oe_n && !host_oe_n))
    else $error("both ends drive bus");
  AST_RD_WR_EXCL: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes together");
  AST_WR_PULSE: assert property ($fell(wr_n) |-> s_wr_pulse)
    else $error("write strobe shape wrong");
  AST_WR_DATA: assert property (!wr_n |-> !host_oe_n)
    else $error("write data not driven");
  AST_BUSY_START: assert property ($fell(convert_start_n) && !busy |-> ##[1:6] busy)
    else $error("busy did not rise");
  AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt == CONV_CYCLES)
    else $error("busy length wrong");
  AST_BUSY_CAUSE: assert property (convert_start_n[*8] |=> !$rose(busy))
    else $error("busy without start");
endmodule

// >>> pps_tb.sv
// Testbench joining converter and host ends
`timescale 1ns/1ps
`include "pps_map.svh"
module pps_tb;
  // Command word layout of the host
  localparam logic [31:0] WR = 32'h0000_1000;
  localparam logic [31:0] HB = 32'h0000_2000;
  localparam logic [31:0] GO = 32'h0000_4000;
  localparam logic [31:0] WM = 32'h0000_8000;
  localparam logic [31:0] ST = 32'h0001_0000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic shadow_load, tracking;
  logic [11:0] paddr, sample_in, control;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] channel_in;
  logic [7:0] shadow;
  logic [1:0] power_state;
  int error_cnt, compares, cyc;
  pps_if intf();
  pps_device #(.RES_BITS(12), .CONV_CYCLES(`PPS_CONV_CYCLES)) u_pps_device (
    .pclk(pclk), .presetn(presetn), .port(intf.device), .sample_in(sample_in),
    .channel_in(channel_in), .control(control), .shadow(shadow),
    .shadow_load(shadow_load), .tracking(tracking), .power_state(power_state));
  pps_host #(.STROBE_CYCLES(3)) u_pps_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port(intf.host));
  pps_properties #(.CONV_CYCLES(`PPS_CONV_CYCLES)) u_pps_properties (
    .pclk(pclk), .presetn(presetn), .cs_n(intf.cs_n), .rd_n(intf.rd_n),
    .wr_n(intf.wr_n), .convert_start_n(intf.convert_start_n), .busy(intf.busy),
    .dev_oe_n(intf.dev_oe_n), .host_oe_n(intf.host_oe_n));
  // =====
  // Shared tasks
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pin cycle, then poll until done and idle
  task automatic pin(input logic [31:0] c);
    apb(1'b1, `PPS_REG_CMD, c | GO | ST);
    do apb(1'b0, `PPS_REG_STAT, 32'h0); while (rdat[1:0] !== 2'b10);
    apb(1'b0, `PPS_REG_DATA, 32'h0);
  endtask
  // Start low until busy ends; a later write raises it again
  task automatic conv();
    apb(1'b1, `PPS_REG_CMD, WM);
    do @(posedge pclk); while (intf.busy !== 1'b1);
    do @(posedge pclk); while (intf.busy !== 1'b0);
    repeat (3) @(posedge pclk);
  endtask
  task automatic wake();
    apb(1'b1, `PPS_REG_CMD, WM | ST);
    repeat (6) @(posedge pclk);
  endtask
  // =====
  // Scenarios
  task automatic t_reset();
    chk(control, `PPS_CTRL_RESET);
    chk({10'h0, power_state}, 12'h000);
    chk({11'h0, tracking}, 12'h000);
  endtask
  task automatic t_write();
    pin(WR | WM | 32'h8c3);
    chk(control, 12'h8c3);
    pin(WR | 32'h04a);
    chk(control, 12'h8c3);
    pin(WR | HB | 32'h006);
    chk(control, 12'h64a);
  endtask
  task automatic t_read();
    sample_in <= 12'habc;
    channel_in <= 3'd5;
    conv();
    wake();
    chk({11'h0, tracking}, 12'h001);
    pin(WM);
    chk(rdat[11:0], 12'habc);
    pin(32'h0);
    chk({4'h0, rdat[7:0]}, 12'h0bc);
    pin(HB);
    chk({4'h0, rdat[7:0]}, 12'h0aa);
  endtask
  // Auto modes power down at conversion end and wake on start rise
  task automatic t_power();
    logic [1:0] want [2];
    want[0] = pps_pkg::PPS_PW_OFF;
    want[1] = pps_pkg::PPS_PW_STBY;
    for (int m = 1; m < 3; m++) begin
      pin(WR | WM | (m << 4));
      conv();
      chk({10'h0, power_state}, {10'h0, want[m - 1]});
      wake();
      chk({10'h0, power_state}, {10'h0, pps_pkg::PPS_PW_ON});
    end
    pin(WR | WM | 32'h030);
    chk({10'h0, power_state}, {10'h0, pps_pkg::PPS_PW_OFF});
    chk({11'h0, tracking}, 12'h000);
    pin(WR | WM | 32'h000);
    chk({10'h0, power_state}, {10'h0, pps_pkg::PPS_PW_ON});
    chk({11'h0, tracking}, 12'h001);
  endtask
  // =====
  // Clock, timeout and main sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("wrong value at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sample_in = 12'h000;
    channel_in = 3'd0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_write();
    t_read();
    t_power();
    tally_and_finish();
  end
endmodule
